// ===== bench/dmd_chk.sv
// Checker for the data map decoder; sees only top-level ports.
// Assumes ce_i high whenever requests are made.
`timescale 1ns/100ps
module dmd_chk
	import dmd_pkg::*;
(
	input wire logic clk_i, // Clock
	input wire logic resetn_i, // Reset
	input wire logic req_i, // Request
	input wire logic io_path_i, // Short path
	input wire logic stack_call_i, // Stack
	input wire logic [1:0] addr_mode_i, // Mode
	input wire logic external_memory_enable_i, // Enable
	input wire logic [1:0] wait_states_i, // Waits
	input wire dmd_region_t region_o, // Region
	input wire logic [15:0] addr_o, // Address
	input wire logic [15:0] ptr_next_o, // Pointer
	input wire logic access_ok_o, // Accepted
	input wire logic [3:0] cycles_o, // Cost
	input wire logic external_write_strobe_pin_o, // Write
	input wire logic external_read_strobe_pin_o, // Read
	input wire logic stall_o, // Halt
	input wire logic [7:0] eeprom_address_high_o, // High
	input wire logic mwe_o, // Master enable
	input wire logic eeprom_write_strobe_o, // Busy
	input wire logic ee_rd_o, // Read pulse
	input wire logic ee_wr_o // Write pulse
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);
	wire stb = external_write_strobe_pin_o | external_read_strobe_pin_o;
	wire ext = access_ok_o && region_o == DMD_EXT_SRAM;
	// Cost and strobe checks hang off the answer cycle
	AST_INT_CYC: assert property (access_ok_o && !ext |-> cycles_o == 4'h2) else $error("int cost");
	AST_STB_EXT: assert property (stb |-> ext) else $error("strobe off ext");
	AST_STB_EN: assert property (stb |-> $past(external_memory_enable_i)) else $error("strobe no enable");
	AST_IO_REF: assert property (access_ok_o |-> !($past(io_path_i) && region_o == DMD_EXT_IO)) else $error("io");
	AST_EXT_CYC: assert property (ext && !$past(stack_call_i) |-> cycles_o == 4'h3 + {2'h0, $past(wait_states_i)})
		else $error("ext cost");
	AST_STK_CYC: assert property (ext && $past(stack_call_i) |-> cycles_o == 4'h3 + {1'b0, $past(wait_states_i), 1'b0})
		else $error("stack cost");
	AST_PTR_INC: assert property (access_ok_o && $past(addr_mode_i) == 2'h3 |-> ptr_next_o == addr_o + 16'h0001)
		else $error("postinc");
	// Halt lengths, the write window and the high address bits
	AST_RD_STALL: assert property (ee_rd_o |-> stall_o [*4] ##1 !stall_o) else $error("read halt");
	AST_WR_STALL: assert property (ee_wr_o |-> stall_o [*2] ##1 (!stall_o && eeprom_write_strobe_o))
		else $error("write halt");
	AST_MWE_WIN: assert property ($rose(mwe_o) |-> mwe_o [*4] ##1 !mwe_o) else $error("window");
	AST_HI_ZERO: assert property (eeprom_address_high_o[7:4] == 4'h0) else $error("high bits");
	cover property (ext);
	cover property (ee_wr_o);
	cover property ($past(req_i) && !access_ok_o);
endmodule // dmd_chk
bind dmd_decoder dmd_chk u_chk (.*);

// ===== bench/dmd_xsram.sv
// External SRAM stand-in: counts bytes moved by the strobes.
// Assumes one-cycle strobe pulses on the CPU clock.
`timescale 1ns/100ps
module dmd_xsram (
	input wire logic clk_i, // CPU clock
	input wire logic wr_i, // Write strobe
	input wire logic rd_i, // Read strobe
	output int wr_n_o, // Writes seen
	output int rd_n_o // Reads seen
);
	initial begin
		wr_n_o = 0;
		rd_n_o = 0;
	end
	always @(posedge clk_i) begin
		wr_n_o <= wr_n_o + int'(wr_i);
		rd_n_o <= rd_n_o + int'(rd_i);
	end
endmodule // dmd_xsram

// ===== bench/tb_top.sv
// Self-checking bench for the data map decoder.
// Assumes a 200 MHz clock and a shortened write time.
`timescale 1ns/100ps
module tb_top;
	import dmd_pkg::*;
	localparam int EWC = 20;
	typedef struct packed {dmd_region_t r; logic ok; logic [3:0] c; logic w; logic rd; logic pw; logic [15:0] a;} dmd_exp_t;
	logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, legacy_mode_i = 1'b0, req_i = 1'b0, we_i = 1'b0;
	logic io_path_i = 1'b0, stack_call_i = 1'b0, external_memory_enable_i = 1'b0, ear_wr_lo_i = 1'b0;
	logic ear_wr_hi_i = 1'b0, ee_read_i = 1'b0, mwe_set_i = 1'b0, eeprom_write_strobe_set_i = 1'b0;
	logic taken = 1'b0, leg = 1'b0;
	logic [1:0] addr_mode_i = 2'h0, wait_states_i = 2'h0;
	logic [15:0] direct_addr_i = 16'h0000, ptr_i = 16'h0000;
	logic [5:0] disp_i = 6'h00, ds = 6'h3F;
	logic [7:0] ear_wdata_i = 8'h00, eeprom_address_low_o, eeprom_address_high_o;
	dmd_region_t region_o;
	logic [15:0] addr_o, ptr_next_o;
	logic [3:0] cycles_o;
	logic [11:0] ee_addr_o;
	logic ptr_we_o, access_ok_o, external_write_strobe_pin_o, external_read_strobe_pin_o, stall_o;
	logic mwe_o, eeprom_write_strobe_o, ee_rd_o, ee_wr_o;
	logic [15:0] am [11] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060, 16'h00FF, 16'h0100,
		16'h0FFF, 16'h1000, 16'h10FF, 16'h1100, 16'hFFFF};
	int mismatches = 0, tests_run = 0, n, xw = 0, xr = 0, wr_n, rd_n;
	dmd_exp_t q[$], e;
	dmd_decoder #(.EE_WRITE_CYCLES(EWC)) dut_u (.*);
	dmd_xsram xs_u (.clk_i(clk_i), .wr_i(external_write_strobe_pin_o), .rd_i(external_read_strobe_pin_o),
		.wr_n_o(wr_n), .rd_n_o(rd_n));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic chk(input string s, input logic [15:0] g, input logic [15:0] x);
		tests_run++;
		if (g !== x) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", s, x, g);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Expected answer worked out from the map and cost rules
	function automatic dmd_exp_t exp_of(input logic [1:0] m, input logic [15:0] a, input logic w, io, st, en,
		input logic [1:0] ws);
		dmd_exp_t x;
		x.r = a < 16'h0020 ? DMD_REG_FILE : a < 16'h0060 ? DMD_STD_IO : (!leg && a < 16'h0100) ? DMD_EXT_IO :
			a < (leg ? 16'h1000 : 16'h1100) ? DMD_INT_SRAM : DMD_EXT_SRAM;
		x.ok = !(io && x.r == DMD_EXT_IO) && !(x.r == DMD_EXT_SRAM && !en);
		x.c = x.r != DMD_EXT_SRAM ? 4'h2 : st ? 4'h3 + {1'b0, ws, 1'b0} : 4'h3 + {2'h0, ws};
		x.w = x.ok && x.r == DMD_EXT_SRAM && w;
		x.rd = x.ok && x.r == DMD_EXT_SRAM && !w;
		x.pw = x.ok && m[1];
		x.a = a;
		return x;
	endfunction
	// One request per cycle; req_i stays up so calls run back to back
	task automatic acc(input logic [1:0] m, input logic [15:0] a, input logic w, io, st, en, input logic [1:0] ws);
		dmd_exp_t x;
		addr_mode_i = m;
		direct_addr_i = a;
		ptr_i = a;
		disp_i = ds;
		we_i = w;
		io_path_i = io;
		stack_call_i = st;
		external_memory_enable_i = en;
		wait_states_i = ws;
		req_i = 1'b1;
		x = exp_of(m, m == 2'h0 ? a : m == 2'h1 ? a + {10'h000, ds} : m == 2'h2 ? a - 16'h0001 : a, w, io, st, en, ws);
		xw += int'(x.w);
		xr += int'(x.rd);
		q.push_back(x);
		@(negedge clk_i);
	endtask
	task automatic rst(input logic l);
		req_i = 1'b0;
		resetn_i = 1'b0;
		leg = l;
		legacy_mode_i = l;
		repeat (12) @(negedge clk_i);
		chk("rg0", region_o, 16'h0007);
		resetn_i = 1'b1;
		repeat (4) @(negedge clk_i);
	endtask
	task automatic sweep;
		foreach (am[i]) acc(2'h0, am[i], i[0], 1'b0, 1'b0, 1'b1, 2'h0);
		req_i = 1'b0;
		@(negedge clk_i);
		$display("map sweep done, legacy %0d", leg);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk_i);
		s = 1'b0;
	endtask
	task automatic cnt(ref logic s);
		n = 0;
		while (s === 1'b1 && n < 100) begin
			n++;
			@(negedge clk_i);
		end
	endtask
	// Answers are registered, so note them at the edge that takes the request
	always @(posedge clk_i) taken <= req_i & ce_i;
	// Compare each answer with the oldest note
	always @(negedge clk_i) begin
		if (taken) begin
			e = q.pop_front();
			chk("ok", access_ok_o, e.ok);
			chk("wr", external_write_strobe_pin_o, e.w);
			chk("rd", external_read_strobe_pin_o, e.rd);
			chk("pw", ptr_we_o, e.pw);
			if (e.ok) begin
				chk("rg", region_o, e.r);
				chk("cy", cycles_o, e.c);
				chk("ad", addr_o, e.a);
			end
		end
	end
	initial begin
		void'($urandom(47364));
		rst(1'b0);
		sweep;
		for (int w = 0; w < 4; w++) begin
			acc(2'h0, 16'h2000, w[0], 1'b0, 1'b0, 1'b1, w[1:0]);
			acc(2'h0, 16'hF000, 1'b1, 1'b0, 1'b1, 1'b1, w[1:0]);
		end
		// refusals beside an allowed short-path access
		acc(2'h0, 16'h0080, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0);
		acc(2'h0, 16'h0040, 1'b0, 1'b1, 1'b0, 1'b1, 2'h0);
		acc(2'h0, 16'h3000, 1'b1, 1'b0, 1'b0, 1'b0, 2'h0);
		acc(2'h1, 16'h0100, 1'b0, 1'b0, 1'b0, 1'b1, 2'h0);
		repeat (8) begin
			ds = 6'($urandom);
			acc(2'($urandom), 16'($urandom), 1'($urandom), 1'b0, 1'b0, 1'b1, 2'($urandom));
		end
		req_i = 1'b0;
		@(negedge clk_i);
		$display("access tests done");
		ear_wdata_i = 8'hFF;
		pulse(ear_wr_hi_i);
		ear_wdata_i = 8'hA5;
		pulse(ear_wr_lo_i);
		chk("eh", eeprom_address_high_o, 16'h000F);
		chk("ea", ee_addr_o, 16'h0FA5);
		pulse(ee_read_i);
		chk("er", ee_rd_o, 16'h0001);
		cnt(stall_o);
		chk("rs", 16'(n), 16'h0004);
		pulse(eeprom_write_strobe_set_i);
		chk("lone", eeprom_write_strobe_o, 16'h0000);
		// Frozen clock enable: a master enable set must not open the window
		ce_i = 1'b0;
		pulse(mwe_set_i);
		ce_i = 1'b1;
		chk("frz", mwe_o, 16'h0000);
		pulse(mwe_set_i);
		repeat (4) @(negedge clk_i);
		chk("mw", mwe_o, 16'h0000);
		pulse(eeprom_write_strobe_set_i);
		chk("late", eeprom_write_strobe_o, 16'h0000);
		pulse(mwe_set_i);
		repeat (3) @(negedge clk_i);
		pulse(eeprom_write_strobe_set_i);
		chk("ww", ee_wr_o, 16'h0001);
		cnt(stall_o);
		chk("ws", 16'(n), 16'h0002);
		// Address writes and reads are refused while the write runs
		ear_wdata_i = 8'h3C;
		pulse(ear_wr_lo_i);
		chk("lock", ee_addr_o, 16'h0FA5);
		pulse(ee_read_i);
		chk("rbusy", ee_rd_o, 16'h0000);
		cnt(eeprom_write_strobe_o);
		chk("wt", 16'(n), 16'(EWC - 4));
		$display("eeprom tests done");
		rst(1'b1);
		sweep;
		chk("xw", 16'(wr_n), 16'(xw));
		chk("xr", 16'(rd_n), 16'(xr));
		wrap_up;
	end
	// Watchdog: whole run needs well under 400 cycles
	initial begin
		repeat (3000) @(posedge clk_i);
		mismatches++;
		wrap_up;
	end
endmodule // tb_top

// ===== common/dmd_map.svh
// Constants for the data memory map decoder: region bounds, cycle costs, timings.
// Assumes inclusion by bare name from the design files.
`ifndef DMD_MAP_SVH
`define DMD_MAP_SVH
`define DMD_REGFILE_END 16'h0020
`define DMD_STDIO_END 16'h0060
`define DMD_EXTIO_END 16'h0100
`define DMD_NORM_SRAM_END 16'h1100
`define DMD_LEG_SRAM_END 16'h1000
`define DMD_DISP_MAX 6'h3F
`define DMD_INT_CYCLES 4'h2
`define DMD_EXT_EXTRA 4'h1
`define DMD_STACK_EXTRA 4'h3
`define DMD_EE_READ_STALL 3'h4
`define DMD_EE_WRITE_STALL 3'h2
`define DMD_MWE_WINDOW 3'h4
`define DMD_EE_WRITE_OSC_CYCLES 8448
`define DMD_EE_OSC_NS 1000
`define DMD_CLK_NS 5
`define DMD_EEPROM_ADDRESS_HI_MASK 8'h0F
`endif

// ===== common/dmd_pkg.sv
// Types for the data memory map decoder.
// Assumes dmd_map.svh is on the include path.
package dmd_pkg;
	typedef enum logic [2:0] {
		DMD_REG_FILE = 3'h0,
		DMD_STD_IO = 3'h1,
		DMD_EXT_IO = 3'h3,
		DMD_INT_SRAM = 3'h2,
		DMD_EXT_SRAM = 3'h6,
		DMD_NONE = 3'h7
	} dmd_region_t;
	typedef enum logic [1:0] {
		DMD_EE_IDLE = 2'h0,
		DMD_EE_STALL = 2'h1,
		DMD_EE_WRITING = 2'h3
	} dmd_ee_state_t;
endpackage

// ===== design/dmd_addr_gen.sv
// Effective address generator: direct, displacement, pre-decrement, post-increment.
// Assumes pointer values come from the register file on the same clock.
`timescale 1ns/100ps
`include "dmd_map.svh"
module dmd_addr_gen
	import dmd_pkg::*;
(
	input wire logic [1:0] mode_i, // 0 direct,1 disp,2 predec,3 postinc
	input wire logic [15:0] direct_i, // Direct address
	input wire logic [15:0] ptr_i, // X, Y or Z pointer value
	input wire logic [5:0] disp_i, // Displacement
	output logic [15:0] addr_o, // Effective address
	output logic [15:0] ptr_next_o // Updated pointer value
);
	wire logic [15:0] ptr_dec = ptr_i - 16'h0001;
	wire logic [15:0] ptr_inc = ptr_i + 16'h0001;
	// displacement reach, limited to six bits so at most 63 beyond base
	wire logic [15:0] disp_addr = ptr_i + {10'h000, disp_i & `DMD_DISP_MAX};
	assign ptr_next_o = (mode_i == 2'h2) ? ptr_dec : (mode_i == 2'h3) ? ptr_inc : ptr_i;
	assign addr_o = (mode_i == 2'h0) ? direct_i : (mode_i == 2'h1) ? disp_addr :
		(mode_i == 2'h2) ? ptr_dec : ptr_i;
endmodule // dmd_addr_gen

// ===== design/dmd_decoder.sv
// Data memory map decoder: region select, access cost, external strobes,
// EEPROM address register pair, master write enable window and write timer.
// Assumes the CPU presents one access request per strobe and honours stall_o.
// Notes on behaviour
// - Normal map: 32 register file, 64 standard I/O, 160 extended I/O, 4096 SRAM.
// - Legacy map: 32 register file, 64 standard I/O, 4000 SRAM.
// - Extended I/O only by load/store, never by short in/out path.
// - Legacy mode removes extended I/O.
// - All addresses above internal SRAM belong to external SRAM.
// - External region uses same instructions; strobes idle on internal accesses.
// - External accesses happen only when external memory enable is set.
// - External byte without wait states costs one extra cycle.
// - One, two, three wait states add two, three, four cycles.
// - Stack in external SRAM: calls add three, or five/seven/nine with waits; cycles_o gives 3/5/7/9 in all, one/three/five/seven above internal.
// - Internal SRAM access takes two cycles.
// - Displacement reaches up to 63 beyond the Y or Z base.
// - Pre-decrement and post-increment update the pointer used.
// - 4 KB byte-wide EEPROM in its own address space.
// - EEPROM read stalls the CPU four cycles.
// - Starting EEPROM write stalls the CPU two cycles.
// - Self-timed write with status showing when next byte may go.
// - Master write enable clears after four cycles; strobe only counts inside.
// - Write strobe clears when the write time (8448 us-osc cycles) ends.
`timescale 1ns/100ps
`include "dmd_map.svh"
module dmd_decoder
	import dmd_pkg::*;
#(
	parameter int EE_WRITE_CYCLES = (`DMD_EE_WRITE_OSC_CYCLES * `DMD_EE_OSC_NS) / `DMD_CLK_NS
)(
	input wire logic clk_i, // CPU clock
	input wire logic resetn_i, // Async reset, active low
	input wire logic ce_i, // Clock enable
	input wire logic legacy_mode_i, // Legacy map strap, async pin
	input wire logic req_i, // Data access request pulse
	input wire logic we_i, // Access is a write
	input wire logic io_path_i, // Access uses short in/out path
	input wire logic stack_call_i, // Two-byte stack access of call/return/interrupt
	input wire logic [1:0] addr_mode_i, // Addressing mode
	input wire logic [15:0] direct_addr_i, // Direct address
	input wire logic [15:0] ptr_i, // Pointer register value
	input wire logic [5:0] disp_i, // Displacement
	input wire logic external_memory_enable_i, // Enable bit from mcu_control_register
	input wire logic [1:0] wait_states_i, // External wait states
	input wire logic ear_wr_lo_i, // Write eeprom_address_low
	input wire logic ear_wr_hi_i, // Write eeprom_address_high
	input wire logic [7:0] ear_wdata_i, // Address write data
	input wire logic ee_read_i, // Read enable written to one
	input wire logic mwe_set_i, // Master write enable written to one
	input wire logic eeprom_write_strobe_set_i, // Write strobe written to one
	output dmd_region_t region_o, // Registered region of last access
	output logic [15:0] addr_o, // Registered effective address
	output logic [15:0] ptr_next_o, // Registered updated pointer
	output logic ptr_we_o, // Pointer write-back pulse
	output logic access_ok_o, // Access accepted
	output logic [3:0] cycles_o, // Cycle cost of last access
	output logic external_write_strobe_pin_o, // External write strobe
	output logic external_read_strobe_pin_o, // External read strobe
	output logic stall_o, // CPU halt
	output logic [7:0] eeprom_address_low_o, // eeprom_address_low readback
	output logic [7:0] eeprom_address_high_o, // eeprom_address_high readback
	output logic [11:0] ee_addr_o, // EEPROM array address
	output logic mwe_o, // Master write enable state
	output logic eeprom_write_strobe_o, // Write in progress
	output logic ee_rd_o, // EEPROM array read pulse
	output logic ee_wr_o // EEPROM array write start pulse
);
	localparam int CW = $clog2(EE_WRITE_CYCLES + 1);
	logic leg_s1, leg_s2, legacy, leg_cap;
	logic leg_v1, leg_v2;
	logic [11:0] eeprom_address;
	logic [2:0] mwe_cnt;
	logic [2:0] stall_cnt;
	logic [CW-1:0] wr_cnt;
	dmd_ee_state_t state, next_state;
	wire logic [15:0] eff_addr;
	wire logic [15:0] eff_ptr_next;
	dmd_region_t region;

	dmd_addr_gen u_addr (
		.mode_i(addr_mode_i),
		.direct_i(direct_addr_i),
		.ptr_i(ptr_i),
		.disp_i(disp_i),
		.addr_o(eff_addr),
		.ptr_next_o(eff_ptr_next)
	);
	dmd_region_dec u_dec (
		.addr_i(eff_addr),
		.legacy_i(legacy),
		.region_o(region)
	);

	// Access qualification: ext I/O refused on in/out path, external needs enable
	// short path cannot reach extended I/O
	wire logic io_refused = io_path_i && region == DMD_EXT_IO;
	// external access gated by the enable bit
	wire logic ext_refused = region == DMD_EXT_SRAM && !external_memory_enable_i;
	wire logic ok = req_i && !io_refused && !ext_refused;
	wire logic is_ext = ok && region == DMD_EXT_SRAM;
	// per-byte extra is 1, then waits+1
	wire logic [3:0] ext_extra = (wait_states_i == 2'h0) ? `DMD_EXT_EXTRA : {2'h0, wait_states_i} + 4'h1;
	// two-byte stack extra is 3, then 2*waits+3
	wire logic [3:0] stk_extra = `DMD_STACK_EXTRA + {2'h0, wait_states_i} + {2'h0, wait_states_i};
	wire logic [3:0] cost = !is_ext ? `DMD_INT_CYCLES :
		stack_call_i ? stk_extra : `DMD_INT_CYCLES + ext_extra;
	wire logic ptr_upd = ok && addr_mode_i[1];
	wire logic busy = state != DMD_EE_IDLE;
	// strobe only honoured inside the master enable window
	wire logic wr_start = eeprom_write_strobe_set_i && mwe_o && !eeprom_write_strobe_o;
	// read or address change refused while writing
	wire logic rd_start = ee_read_i && !eeprom_write_strobe_o && !busy;
	wire logic ear_lock = eeprom_write_strobe_o;
	// Strobe qualifiers split by direction
	wire logic ext_wr = is_ext && we_i;
	wire logic ext_rd = is_ext && !we_i;
	// Stall loads only from idle, so a stray request mid-stall cannot restart it
	wire logic rd_load = !busy && rd_start;
	wire logic wr_load = !busy && wr_start;
	wire logic stall_run = stall_cnt != 3'h0;
	wire logic stall_last = stall_cnt == 3'h1;

	// Legacy strap synchroniser; second stage feeds capture only
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			leg_s1 <= 1'b0;
			leg_s2 <= 1'b0;
		end else if (ce_i) begin
			leg_s1 <= legacy_mode_i;
			leg_s2 <= leg_s1;
		end
	end

	// Valid pipeline: marks when the second stage holds a real strap sample
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			leg_v1 <= 1'b0;
			leg_v2 <= 1'b0;
		end else if (ce_i) begin
			leg_v1 <= 1'b1;
			leg_v2 <= leg_v1;
		end
	end

	// latched once, third edge after reset, so the map cannot move later
	// Capturing any earlier would take the synchroniser's reset value, not the strap
	wire logic leg_take = leg_v2 && !leg_cap;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			legacy <= 1'b0;
			leg_cap <= 1'b0;
		end else if (ce_i && leg_take) begin
			legacy <= leg_s2;
			leg_cap <= 1'b1;
		end
	end

	// Held results: region, address and cost stand until the next request
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			region_o <= DMD_NONE;
			addr_o <= 16'h0000;
			cycles_o <= 4'h0;
		end else if (ce_i && req_i) begin
			region_o <= region;
			addr_o <= eff_addr;
			cycles_o <= cost;
		end
	end

	// Pointer result; the write-back pulse tells the CPU when to use it
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ptr_next_o <= 16'h0000;
			ptr_we_o <= 1'b0;
		end else if (ce_i) begin
			ptr_next_o <= eff_ptr_next;
			ptr_we_o <= ptr_upd;
		end
	end

	// One-cycle answer pulse and external strobes
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			access_ok_o <= 1'b0;
			external_write_strobe_pin_o <= 1'b0;
			external_read_strobe_pin_o <= 1'b0;
		end else if (ce_i) begin
			access_ok_o <= ok;
			// strobes stay low for internal accesses
			external_write_strobe_pin_o <= ext_wr;
			external_read_strobe_pin_o <= ext_rd;
		end
	end

	// address pair; reset leaves it at zero as a defined stand-in
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			eeprom_address <= 12'h000;
		end else if (ce_i && !ear_lock) begin
			if (ear_wr_lo_i)
				eeprom_address[7:0] <= ear_wdata_i;
			if (ear_wr_hi_i)
				eeprom_address[11:8] <= ear_wdata_i[3:0];
		end
	end
	assign eeprom_address_high_o = {4'h0, eeprom_address[11:8]} & `DMD_EEPROM_ADDRESS_HI_MASK;
	assign eeprom_address_low_o = eeprom_address[7:0];
	// 12-bit byte address into separate space
	assign ee_addr_o = eeprom_address;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mwe_o <= 1'b0;
			mwe_cnt <= 3'h0;
		end else if (ce_i) begin
			if (mwe_set_i) begin
				mwe_o <= 1'b1;
				mwe_cnt <= `DMD_MWE_WINDOW - 3'h1;
			end else if (mwe_o) begin
				mwe_o <= mwe_cnt != 3'h0;
				mwe_cnt <= mwe_cnt - 3'h1;
			end
		end
	end

	// Stall sequencer state
	always_comb begin
		next_state = state;
		case (state)
			DMD_EE_IDLE:
				if (rd_start || wr_start)
					next_state = DMD_EE_STALL;
			DMD_EE_STALL:
				if (stall_cnt == 3'h1)
					next_state = eeprom_write_strobe_o ? DMD_EE_WRITING : DMD_EE_IDLE;
			DMD_EE_WRITING:
				if (!eeprom_write_strobe_o)
					next_state = DMD_EE_IDLE;
			default:
				next_state = DMD_EE_IDLE;
		endcase
	end

	// Sequencer state and the EEPROM array pulses
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state <= DMD_EE_IDLE;
			ee_rd_o <= 1'b0;
			ee_wr_o <= 1'b0;
		end else if (ce_i) begin
			state <= next_state;
			ee_rd_o <= rd_start;
			ee_wr_o <= wr_start;
		end
	end

	// stall counts for read and write start
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			stall_cnt <= 3'h0;
			stall_o <= 1'b0;
		end else if (ce_i) begin
			if (rd_load) begin
				stall_cnt <= `DMD_EE_READ_STALL;
				stall_o <= 1'b1;
			end else if (wr_load) begin
				stall_cnt <= `DMD_EE_WRITE_STALL;
				stall_o <= 1'b1;
			end else if (stall_run) begin
				stall_cnt <= stall_cnt - 3'h1;
				stall_o <= !stall_last;
			end
		end
	end

	// self-timed write; strobe reads back as busy until time elapses
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			eeprom_write_strobe_o <= 1'b0;
			wr_cnt <= '0;
		end else if (ce_i) begin
			if (wr_start) begin
				eeprom_write_strobe_o <= 1'b1;
				wr_cnt <= CW'(EE_WRITE_CYCLES - 1);
			end else if (eeprom_write_strobe_o) begin
				wr_cnt <= wr_cnt - CW'(1);
				if (wr_cnt == '0)
					eeprom_write_strobe_o <= 1'b0;
			end
		end
	end
endmodule // dmd_decoder

// ===== design/dmd_region_dec.sv
// Combinational region decoder for the 64K data space.
// Assumes the legacy flag is already stable.
`timescale 1ns/100ps
`include "dmd_map.svh"
module dmd_region_dec
	import dmd_pkg::*;
(
	input wire logic [15:0] addr_i, // Data address
	input wire logic legacy_i, // Legacy map selected
	output dmd_region_t region_o // Decoded region
);
	wire logic [15:0] sram_end = legacy_i ? `DMD_LEG_SRAM_END : `DMD_NORM_SRAM_END;
	// extended I/O disappears in legacy mode
	wire logic in_ext_io = !legacy_i && addr_i < `DMD_EXTIO_END;
	// everything above internal SRAM is external
	assign region_o = (addr_i < `DMD_REGFILE_END) ? DMD_REG_FILE :
		(addr_i < `DMD_STDIO_END) ? DMD_STD_IO :
		in_ext_io ? DMD_EXT_IO :
		(addr_i < sram_end) ? DMD_INT_SRAM : DMD_EXT_SRAM;
endmodule // dmd_region_dec
